//--- ccpt_top.sv
// Two capture/compare/PWM units with timer pairing, AXI4-Lite register slave
//
// The implementer's own choice: register access over AXI4-Lite.
`include "ccpt_defines.svh"

// Functional notes
// - Control bit 7 enables unit, resets 0
// - Control bit 5 reads present output level
// - Bit 4 picks PWM duty alignment
// - Mode 0000 off; 11xx PWM; events flag
// - Capture on any/fall/rise/4th/16th edge
// - Codes 0010/0001 toggle; 0001 clears timer
// - Codes 1010/1011 pulse; 1011 clears timer
// - 1000 sets, 1001 clears; off resets level
// - Clear the currently selected timer
// - Trigger selector picks pin, comparator, cells
// - Value register survives all resets
// - Capture/compare: high byte 15:8, low 7:0
// - Right-aligned PWM duty in bits 9:0
// - Left-aligned PWM duty in bits 15:6
// - Per-unit timer selection, defaults first timers
// - Selection 01 first pair, 10 second
// - Period match clears timer, sets pin unless new duty is 0, buffers
// - Time base equal duty buffer clears pin
module ccpt_top (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write
  input  wire logic [`CCPT_ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // AXI4-Lite read
  input  wire logic [`CCPT_ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // Capture sources, asynchronous
  input  wire logic [1:0]              unit_pin_in,
  input  wire logic                    comparator_one_result,
  input  wire logic                    comparator_two_result,
  input  wire logic                    pin_change_interrupt,
  input  wire logic [3:0]              logic_cell_results,
  // 16-bit capture/compare timers
  input  wire logic [15:0]             timer1_count,
  input  wire logic [15:0]             timer3_count,
  // 8-bit PWM timers
  input  wire logic [7:0]              timer2_count,
  input  wire logic [1:0]              timer2_low,
  input  wire logic [7:0]              timer2_period,
  input  wire logic                    timer2_step,
  input  wire logic [7:0]              timer4_count,
  input  wire logic [1:0]              timer4_low,
  input  wire logic [7:0]              timer4_period,
  input  wire logic                    timer4_step,
  // Unit outputs
  output logic [1:0]                   unit_pin_out,
  output logic [1:0]                   unit_event_flag,
  output logic [3:0]                   timer_clear
);
  import ccpt_pkg::*;

  function automatic ccpt_reg_type ccpt_decode(input logic [`CCPT_ADDR_W-1:0] a);
    logic [11:0] idx;
    idx = a[13:2];
    if (a[`CCPT_ADDR_W-1:14] != '0)
      return REG_NONE;
    case (idx)
      `CCPT_IDX_VAL1: return REG_VAL1;
      `CCPT_IDX_CON1: return REG_CON1;
      `CCPT_IDX_CAP1: return REG_CAP1;
      `CCPT_IDX_VAL2: return REG_VAL2;
      `CCPT_IDX_CON2: return REG_CON2;
      `CCPT_IDX_CAP2: return REG_CAP2;
      `CCPT_IDX_TSEL: return REG_TSEL;
      default:        return REG_NONE;
    endcase
  endfunction : ccpt_decode

  // Reserved trigger codes read as a quiet low input
  function automatic logic ccpt_trig(input logic [3:0] sel, input logic pin,
                                     input logic [6:0] shared);
    if (sel == SRC_PIN)
      return pin;
    else if (sel[3] == 1'b0)
      return shared[3'(sel[2:0] - 3'h1)];
    else
      return 1'b0;
  endfunction : ccpt_trig

  function automatic logic [9:0] ccpt_duty(input logic [15:0] v, input logic fmt);
    return fmt ? v[15:6] : v[9:0];
  endfunction : ccpt_duty

  function automatic logic [15:0] ccpt_keep(input logic pwm, input logic fmt);
    if (!pwm)
      return `CCPT_KEEP_ALL;
    return fmt ? `CCPT_KEEP_LEFT : `CCPT_KEEP_RIGHT;
  endfunction : ccpt_keep

  // Bus state
  logic                    awready_q, awready_d, wready_q, wready_d;
  logic                    aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [`CCPT_ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0]             wdat_q, wdat_d;
  logic [3:0]              wstb_q, wstb_d;
  logic                    bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]              bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    do_write;
  ccpt_reg_type            wreg, rreg;

  // Unit state
  logic [1:0]              en_q, en_d, fmt_q, fmt_d, pin_q, pin_d;
  ccpt_mode_type           mode_q [2];
  ccpt_mode_type           mode_d [2];
  logic [3:0]              capsel_q [2];
  logic [3:0]              capsel_d [2];
  logic [3:0]              pre_q [2];
  logic [3:0]              pre_d [2];
  logic [9:0]              duty_q [2];
  logic [9:0]              duty_d [2];
  logic [15:0]             val_q [2];
  logic [15:0]             val_d [2];
  logic [15:0]             cnt_sel [2];
  logic [1:0]              trig_q, trig_d, eq_q, eq_d, evt_q, evt_d;
  logic [1:0]              cap_hit, cmp_hit, per_hit;
  logic [7:0]              tsel_q, tsel_d;
  logic [3:0]              clr_q, clr_d;
  logic [8:0]              sync1_q, sync2_q;

  assign awready         = awready_q;
  assign wready          = wready_q;
  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;
  assign arready         = arready_q;
  assign rvalid          = rvalid_q;
  assign rdata           = rdata_q;
  assign rresp           = rresp_q;
  assign unit_pin_out    = pin_q;
  assign unit_event_flag = evt_q;
  assign timer_clear     = clr_q;

  assign wreg     = ccpt_decode(waddr_q);
  assign rreg     = ccpt_decode(araddr);
  assign do_write = aw_have_q & w_have_q;

  // Address and data are held separately so either may arrive first
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wdat_d    = wdat_q;
    wstb_d    = wstb_q;
    bvalid_d  = bvalid_q & ~bready;
    bresp_d   = bresp_q;
    if (awvalid & awready_q)
    begin
      aw_have_d = 1'b1;
      waddr_d   = awaddr;
    end
    if (wvalid & wready_q)
    begin
      w_have_d = 1'b1;
      wdat_d   = wdata;
      wstb_d   = wstrb;
    end
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wreg == REG_NONE) ? `CCPT_RESP_SLVERR : `CCPT_RESP_OKAY;
    end
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d  = ~w_have_d & ~bvalid_d;
    rvalid_d  = rvalid_q & ~rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (arvalid & arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = (rreg == REG_NONE) ? `CCPT_RESP_SLVERR : `CCPT_RESP_OKAY;
      case (rreg)
        REG_VAL1: rdata_d = {16'h0000, val_q[0]};
        REG_VAL2: rdata_d = {16'h0000, val_q[1]};
        REG_CON1: rdata_d = {24'h000000, en_q[0], 1'b0, pin_q[0], fmt_q[0], mode_q[0]};
        REG_CON2: rdata_d = {24'h000000, en_q[1], 1'b0, pin_q[1], fmt_q[1], mode_q[1]};
        REG_CAP1: rdata_d = {28'h0000000, capsel_q[0]};
        REG_CAP2: rdata_d = {28'h0000000, capsel_q[1]};
        REG_TSEL: rdata_d = {24'h000000, 4'h0, tsel_q[3:0]};
        default:  rdata_d = 32'h00000000;
      endcase
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= '0;
      wdat_q    <= 32'h00000000;
      wstb_q    <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CCPT_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `CCPT_RESP_OKAY;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      waddr_q   <= waddr_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Pins and neighbour outputs are asynchronous
  always_ff @(posedge aclk)
  begin
    sync1_q <= {logic_cell_results, pin_change_interrupt, comparator_two_result,
                comparator_one_result, unit_pin_in};
    sync2_q <= sync1_q;
  end

  always_comb
  begin
    logic        act, pwm, cap, cmp, trig, rise, fall, step, clr_tmr;
    logic [1:0]  tsel;
    logic [7:0]  pcnt, pper;
    logic [1:0]  plow;
    logic [9:0]  new_duty;
    logic [15:0] bmask, keep;
    act      = 1'b0;
    pwm      = 1'b0;
    cap      = 1'b0;
    cmp      = 1'b0;
    trig     = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    step     = 1'b0;
    clr_tmr  = 1'b0;
    tsel     = 2'h0;
    pcnt     = 8'h00;
    pper     = 8'h00;
    plow     = 2'h0;
    new_duty = 10'h000;
    bmask    = 16'h0000;
    keep     = 16'h0000;
    clr_d    = 4'h0;
    tsel_d   = tsel_q;
    if (do_write && wreg == REG_TSEL && wstb_q[0])
      tsel_d = {4'h0, wdat_q[3:0]};
    for (int i = 0; i < 2; i++)
    begin
      en_d[i]     = en_q[i];
      fmt_d[i]    = fmt_q[i];
      mode_d[i]   = mode_q[i];
      capsel_d[i] = capsel_q[i];
      val_d[i]    = val_q[i];
      if (do_write && wreg == ((i == 0) ? REG_CON1 : REG_CON2) && wstb_q[0])
      begin
        en_d[i]   = wdat_q[`CCPT_EN_BIT];
        fmt_d[i]  = wdat_q[`CCPT_FMT_BIT];
        mode_d[i] = ccpt_mode_type'(wdat_q[3:0]);
      end
      if (do_write && wreg == ((i == 0) ? REG_CAP1 : REG_CAP2) && wstb_q[0])
        capsel_d[i] = wdat_q[3:0];
      act  = en_q[i] && (mode_q[i] != MODE_OFF);
      pwm  = act && (mode_q[i][3:2] == 2'b11);
      cap  = act && (mode_q[i] inside {MODE_CAP_ANY, MODE_CAP_FALL, MODE_CAP_RISE,
                                       MODE_CAP_4, MODE_CAP_16});
      cmp  = act && !pwm && !cap;
      tsel = tsel_q[2*i +: 2];
      // Reserved pairings reach no 16-bit timer; PWM compares fall back to timer4
      cnt_sel[i] = (tsel == `CCPT_TSEL_FIRST)  ? timer1_count :
                   (tsel == `CCPT_TSEL_SECOND) ? timer3_count : 16'h0000;
      trig       = ccpt_trig(capsel_q[i], sync2_q[i], sync2_q[8:2]);
      rise       = trig & ~trig_q[i];
      fall       = ~trig & trig_q[i];
      trig_d[i]  = trig;
      case (mode_q[i])
        MODE_CAP_ANY:  cap_hit[i] = cap && (rise || fall);
        MODE_CAP_FALL: cap_hit[i] = cap && fall;
        MODE_CAP_RISE: cap_hit[i] = cap && rise;
        MODE_CAP_4:    cap_hit[i] = cap && rise && (pre_q[i] == `CCPT_PRE_4TH);
        MODE_CAP_16:   cap_hit[i] = cap && rise && (pre_q[i] == `CCPT_PRE_16TH);
        default:       cap_hit[i] = 1'b0;
      endcase
      if (!cap || !(mode_q[i] inside {MODE_CAP_4, MODE_CAP_16}) || cap_hit[i])
        pre_d[i] = 4'h0;
      else if (rise)
        pre_d[i] = pre_q[i] + 4'h1;
      else
        pre_d[i] = pre_q[i];
      // Acting on the first cycle of equality keeps one match to one event
      eq_d[i]    = (cnt_sel[i] == val_q[i]);
      cmp_hit[i] = cmp && eq_d[i] && !eq_q[i];
      clr_tmr    = cmp_hit[i] && (mode_q[i] inside {MODE_TOG_CLR, MODE_PULSE_CLR});
      if (clr_tmr && tsel == `CCPT_TSEL_FIRST)
        clr_d[0] = 1'b1;
      if (clr_tmr && tsel == `CCPT_TSEL_SECOND)
        clr_d[2] = 1'b1;
      pcnt = (tsel == `CCPT_TSEL_FIRST) ? timer2_count  : timer4_count;
      plow = (tsel == `CCPT_TSEL_FIRST) ? timer2_low    : timer4_low;
      pper = (tsel == `CCPT_TSEL_FIRST) ? timer2_period : timer4_period;
      step = (tsel == `CCPT_TSEL_FIRST) ? timer2_step :
             (tsel == `CCPT_TSEL_SECOND) ? timer4_step : 1'b0;
      per_hit[i] = pwm && step && (pcnt == pper);
      new_duty   = ccpt_duty(val_q[i], fmt_q[i]);
      duty_d[i]  = per_hit[i] ? new_duty : duty_q[i];
      if (per_hit[i] && tsel == `CCPT_TSEL_FIRST)
        clr_d[1] = 1'b1;
      if (per_hit[i] && tsel == `CCPT_TSEL_SECOND)
        clr_d[3] = 1'b1;
      if (!act || cap)
        pin_d[i] = 1'b0;
      else if (pwm)
      begin
        if (per_hit[i])
          pin_d[i] = (new_duty != 10'h000);
        else if ({pcnt, plow} == duty_q[i])
          pin_d[i] = 1'b0;
        else
          pin_d[i] = pin_q[i];
      end
      else if (cmp_hit[i])
      begin
        case (mode_q[i])
          MODE_TOG, MODE_TOG_CLR:     pin_d[i] = ~pin_q[i];
          MODE_SET:                   pin_d[i] = 1'b1;
          MODE_CLR:                   pin_d[i] = 1'b0;
          MODE_PULSE, MODE_PULSE_CLR: pin_d[i] = 1'b1;
          default:                    pin_d[i] = pin_q[i];
        endcase
      end
      else if (mode_q[i] inside {MODE_PULSE, MODE_PULSE_CLR})
        pin_d[i] = 1'b0;
      else
        pin_d[i] = pin_q[i];
      evt_d[i] = cap_hit[i] | cmp_hit[i] | per_hit[i];
      // Byte lanes map straight to value bits; PWM drops the unused ones
      bmask = {{8{wstb_q[1]}}, {8{wstb_q[0]}}};
      keep  = ccpt_keep(en_q[i] && (mode_q[i][3:2] == 2'b11), fmt_q[i]);
      if (do_write && wreg == ((i == 0) ? REG_VAL1 : REG_VAL2))
        val_d[i] = ((val_q[i] & ~bmask) | (wdat_q[15:0] & bmask)) & keep;
      // A capture in the same cycle as a software write wins
      if (cap_hit[i])
        val_d[i] = cnt_sel[i];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q   <= 2'h0;
      fmt_q  <= 2'h0;
      pin_q  <= 2'h0;
      trig_q <= 2'h0;
      eq_q   <= 2'h0;
      evt_q  <= 2'h0;
      clr_q  <= 4'h0;
      tsel_q <= `CCPT_TSEL_RST;
      for (int i = 0; i < 2; i++)
      begin
        mode_q[i]   <= MODE_OFF;
        capsel_q[i] <= `CCPT_CAP_RST;
        pre_q[i]    <= 4'h0;
        duty_q[i]   <= 10'h000;
      end
    end
    else
    begin
      en_q   <= en_d;
      fmt_q  <= fmt_d;
      pin_q  <= pin_d;
      trig_q <= trig_d;
      eq_q   <= eq_d;
      evt_q  <= evt_d;
      clr_q  <= clr_d;
      tsel_q <= tsel_d;
      for (int i = 0; i < 2; i++)
      begin
        mode_q[i]   <= mode_d[i];
        capsel_q[i] <= capsel_d[i];
        pre_q[i]    <= pre_d[i];
        duty_q[i]   <= duty_d[i];
      end
    end
  end

  // Value holds through the bus reset; only power-up leaves it unknown
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 2; i++)
      val_q[i] <= val_d[i];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pulse_shape;
    unit_pin_out[0] ##1 !unit_pin_out[0];
  endsequence

  a_enable_off_low: assert property (!en_q[0] |=> !unit_pin_out[0])
    else $error("Disabled unit drives its pin high");
  a_off_no_flag: assert property (mode_q[0] == MODE_OFF |=> !unit_event_flag[0])
    else $error("Mode off raised an event");
  a_pulse_shape: assert property (cmp_hit[0] && mode_q[0] == MODE_PULSE
                                  && en_d[0] && mode_d[0] == MODE_PULSE
                                  |=> s_pulse_shape)
    else $error("Compare pulse is not one cycle wide");
  a_toggle_flip: assert property (cmp_hit[0] && mode_q[0] == MODE_TOG
                                  |=> unit_pin_out[0] != $past(unit_pin_out[0]))
    else $error("Toggle did not flip the pin");
  a_capture_copy: assert property (cap_hit[0] |=> val_q[0] == $past(cnt_sel[0]))
    else $error("Capture did not store the timer count");
  a_clear_timer: assert property (cmp_hit[0] && tsel_q[1:0] == 2'h2
                                  && mode_q[0] inside {MODE_TOG_CLR, MODE_PULSE_CLR}
                                  |=> timer_clear[2])
    else $error("Selected timer was not cleared");
  a_tsel_reset: assert property ($rose(aresetn) |-> tsel_q == 8'h05)
    else $error("Timer selection reset value wrong");
  a_pwm_period: assert property (per_hit[0] && ccpt_duty(val_q[0], fmt_q[0]) != 10'h000
                                 |=> unit_pin_out[0] && unit_event_flag[0])
    else $error("Period event did not set the pin");
  a_write_answer: assert property (do_write |=> bvalid ##0 !awready [*1])
    else $error("Write answer missing");

endmodule : ccpt_top

//--- ccpt_defines.svh
// Register indices, field positions, reset values and bus codes
`ifndef CCPT_DEFINES_SVH
`define CCPT_DEFINES_SVH

`define CCPT_ADDR_W      16
`define CCPT_IDX_VAL1    12'h40C
`define CCPT_IDX_CON1    12'h40E
`define CCPT_IDX_CAP1    12'h40F
`define CCPT_IDX_VAL2    12'h410
`define CCPT_IDX_CON2    12'h412
`define CCPT_IDX_CAP2    12'h413
`define CCPT_IDX_TSEL    12'h41F

`define CCPT_EN_BIT      7
`define CCPT_OUT_BIT     5
`define CCPT_FMT_BIT     4

`define CCPT_CON_RST     8'h00
`define CCPT_CAP_RST     4'h0
`define CCPT_TSEL_RST    8'h05

`define CCPT_TSEL_FIRST  2'h1
`define CCPT_TSEL_SECOND 2'h2

`define CCPT_KEEP_ALL    16'hFFFF
`define CCPT_KEEP_LEFT   16'hFFC0
`define CCPT_KEEP_RIGHT  16'h03FF

`define CCPT_PRE_4TH     4'h3
`define CCPT_PRE_16TH    4'hF

`define CCPT_RESP_OKAY   2'h0
`define CCPT_RESP_SLVERR 2'h2

`endif

//--- ccpt_pkg.sv
// Types shared by the capture/compare/PWM control block
package ccpt_pkg;

  typedef enum logic [3:0] {
    MODE_OFF       = 4'h0,
    MODE_TOG_CLR   = 4'h1,
    MODE_TOG       = 4'h2,
    MODE_CAP_ANY   = 4'h3,
    MODE_CAP_FALL  = 4'h4,
    MODE_CAP_RISE  = 4'h5,
    MODE_CAP_4     = 4'h6,
    MODE_CAP_16    = 4'h7,
    MODE_SET       = 4'h8,
    MODE_CLR       = 4'h9,
    MODE_PULSE     = 4'hA,
    MODE_PULSE_CLR = 4'hB,
    MODE_PWM_0     = 4'hC,
    MODE_PWM_1     = 4'hD,
    MODE_PWM_2     = 4'hE,
    MODE_PWM_3     = 4'hF
  } ccpt_mode_type;

  typedef enum logic [3:0] {
    SRC_PIN   = 4'h0,
    SRC_CMP1  = 4'h1,
    SRC_CMP2  = 4'h2,
    SRC_IOC   = 4'h3,
    SRC_CELL1 = 4'h4,
    SRC_CELL2 = 4'h5,
    SRC_CELL3 = 4'h6,
    SRC_CELL4 = 4'h7
  } ccpt_src_type;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_VAL1 = 3'h1,
    REG_CON1 = 3'h2,
    REG_CAP1 = 3'h3,
    REG_VAL2 = 3'h4,
    REG_CON2 = 3'h5,
    REG_CAP2 = 3'h6,
    REG_TSEL = 3'h7
  } ccpt_reg_type;

endpackage : ccpt_pkg

//--- ccpt_far_model.sv
// Far-side model: the timers that feed both capture/compare/PWM units
module ccpt_far_model #(
  parameter logic [7:0] PR = 8'h03
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench controls
  input  wire logic        hold,
  input  wire logic        restart,
  // Device side
  input  wire logic [3:0]  timer_clear,
  output logic      [15:0] t16_a,
  output logic      [15:0] t16_b,
  output logic      [7:0]  t8,
  output logic      [1:0]  t8_low,
  output logic             t8_step
);
  timeunit 1ns;
  timeprecision 1ps;

  // Low bits run every cycle, so one period is 4 * (PR + 1) cycles
  assign t8_step = (t8_low == 2'h3);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Distinct starting counts so a capture shows which timer it used
      t16_a  <= 16'h0000;
      t16_b  <= 16'h8000;
      t8     <= 8'h00;
      t8_low <= 2'h0;
    end
    else
    begin
      t16_a  <= (restart || timer_clear[0]) ? 16'h0000 : t16_a + 16'(!hold);
      t16_b  <= (restart || timer_clear[2]) ? 16'h0000 : t16_b + 16'(!hold);
      t8_low <= t8_low + 2'h1;
      // Wraps on its own too; a clear one cycle later then finds it at zero already
      if (timer_clear[1] || timer_clear[3])
        t8 <= 8'h00;
      else if (t8_step)
        t8 <= (t8 == PR) ? 8'h00 : t8 + 8'h01;
    end
  end
endmodule : ccpt_far_model

//--- testbench.sv
// Self-checking bench for the capture/compare/PWM control block
`include "ccpt_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ccpt_pkg::*;

  localparam logic [7:0] PR = 8'h03;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, hold, restart, step;
  logic [15:0] awaddr, araddr, timer1_count, timer3_count;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, timer_clear;
  logic [1:0]  bresp, rresp, unit_pin_out, unit_event_flag, low, rs;
  logic [7:0]  src, t8;
  int          miscompares, comparisons, nflag, nclr0, nclr2, nhigh, nflag2, nclr1, nclr3;

  ccpt_top i_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .unit_pin_in({2{src[0]}}), .comparator_one_result(src[1]), .comparator_two_result(src[2]),
    .pin_change_interrupt(src[3]), .logic_cell_results(src[7:4]), .timer1_count, .timer3_count,
    .timer2_count(t8), .timer2_low(low), .timer2_period(PR), .timer2_step(step),
    .timer4_count(t8), .timer4_low(low), .timer4_period(PR), .timer4_step(step),
    .unit_pin_out, .unit_event_flag, .timer_clear
  );

  ccpt_far_model #(.PR(PR)) i_far (
    .aclk, .aresetn, .hold, .restart, .timer_clear, .t16_a(timer1_count),
    .t16_b(timer3_count), .t8, .t8_low(low), .t8_step(step)
  );

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Non-blocking, so a task sampling at the same edge sees a settled count
  always @(posedge aclk)
  begin
    nflag <= nflag + int'(unit_event_flag[0]);
    nclr0 <= nclr0 + int'(timer_clear[0]);
    nclr2 <= nclr2 + int'(timer_clear[2]);
    nhigh <= nhigh + int'(unit_pin_out[0]);
    nflag2 <= nflag2 + int'(unit_event_flag[1]);
    nclr1 <= nclr1 + int'(timer_clear[1]);
    nclr3 <= nclr3 + int'(timer_clear[3]);
  end

  function automatic logic [31:0] ctl(input logic en, input logic fmt, input ccpt_mode_type m);
    return {24'h0, en, 2'h0, fmt, m};
  endfunction : ctl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    bit ad;
    bit wd;
    @(posedge aclk);
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ad = 0;
    wd = 0;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awready)
      begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (!wd && wready)
      begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    while (!bvalid)
      @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [11:0] idx);
    @(posedge aclk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge aclk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    rdr(idx);
    chk(rd, exp, "register read");
  endtask : rchk

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  // Each half of a pulse spans the synchroniser and edge detector
  task automatic edges(input int b, input int n);
    repeat (2 * n)
    begin
      repeat (4) @(posedge aclk);
      src[b] <= ~src[b];
    end
    repeat (6) @(posedge aclk);
  endtask : edges

  task automatic t_regs();
    rchk(`CCPT_IDX_CON1, 32'h0);
    rchk(`CCPT_IDX_TSEL, 32'h5);
    rdr(12'h400);
    chk({rs, rd[29:0]}, 32'h80000000, "unmapped read");
    wr(12'h400, 32'h1);
    chk(32'(rs), 32'h2, "unmapped write");
    wr(`CCPT_IDX_VAL1, 32'hA5C3);
    rchk(`CCPT_IDX_VAL1, 32'hA5C3);
    do_reset();
    rchk(`CCPT_IDX_VAL1, 32'hA5C3);
  endtask : t_regs

  task automatic t_capval();
    hold <= 1'b1;
    // Unit 2 keeps the first pairing in both passes
    wr(`CCPT_IDX_CON2, ctl(1'b1, 1'b0, MODE_CAP_RISE));
    for (int s = 1; s <= 2; s++)
    begin
      wr(`CCPT_IDX_TSEL, 32'h4 | s);
      wr(`CCPT_IDX_CON1, ctl(1'b1, 1'b0, MODE_CAP_RISE));
      edges(0, 1);
      rchk(`CCPT_IDX_VAL1, s == 1 ? 32'(timer1_count) : 32'(timer3_count));
      rchk(`CCPT_IDX_VAL2, 32'(timer1_count));
      wr(`CCPT_IDX_CON1, 32'h0);
    end
    chk(32'(nflag2), 32'h2, "unit2 events");
    wr(`CCPT_IDX_CON2, 32'h0);
    wr(`CCPT_IDX_TSEL, 32'h5);
    hold <= 1'b0;
  endtask : t_capval

  task automatic t_capture();
    logic [7:0] c [7] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h80, 8'h03};
    int         e [7] = '{32, 16, 16, 4, 1, 0, 0};
    int         n0;
    for (int i = 0; i < 7; i++)
    begin
      wr(`CCPT_IDX_CON1, 32'(c[i]));
      n0 = nflag;
      edges(0, 16);
      chk(32'(nflag - n0), 32'(e[i]), "capture events");
      wr(`CCPT_IDX_CON1, 32'h0);
    end
    wr(`CCPT_IDX_CON1, ctl(1'b1, 1'b0, MODE_CAP_ANY));
    for (int s = 0; s < 9; s++)
    begin
      wr(`CCPT_IDX_CAP1, 32'(s));
      n0 = nflag;
      edges(s % 8, 1);
      chk(32'(nflag - n0), s < 8 ? 32'h2 : 32'h0, "trigger source");
    end
    wr(`CCPT_IDX_CON1, 32'h0);
    wr(`CCPT_IDX_CAP1, 32'h0);
  endtask : t_capture

  task automatic restart_timers();
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
    repeat (100) @(posedge aclk);
  endtask : restart_timers

  task automatic t_compare();
    ccpt_mode_type m [4] = '{MODE_TOG_CLR, MODE_PULSE_CLR, MODE_TOG, MODE_PULSE};
    int            c0, c2, f0, h0;
    wr(`CCPT_IDX_VAL1, 32'h0010);
    for (int i = 0; i < 4; i++)
    begin
      wr(`CCPT_IDX_TSEL, i == 1 ? 32'h6 : 32'h5);
      wr(`CCPT_IDX_CON1, ctl(1'b1, 1'b0, m[i]));
      {c0, c2, f0, h0} = {nclr0, nclr2, nflag, nhigh};
      restart_timers();
      chk(32'(nclr0 > c0), 32'(i == 0), "timer1 clears");
      chk(32'(nclr2 > c2), 32'(i == 1), "timer3 clears");
      chk(32'(nflag > f0), 32'h1, "compare event");
      if (i == 2)
        chk(32'(unit_pin_out[0]), 32'h1, "toggle level");
      if (i == 3)
        chk(32'(nhigh - h0), 32'h1, "pulse width");
      wr(`CCPT_IDX_CON1, 32'h0);
    end
    wr(`CCPT_IDX_TSEL, 32'h5);
    for (int k = 0; k < 2; k++)
    begin
      wr(`CCPT_IDX_CON1, ctl(1'b1, 1'b0, k ? MODE_CLR : MODE_SET));
      restart_timers();
      chk(32'(unit_pin_out[0]), 32'(k == 0), "latched level");
      rchk(`CCPT_IDX_CON1, ctl(1'b1, 1'b0, k ? MODE_CLR : MODE_SET) | 32'(k == 0) << 5);
      wr(`CCPT_IDX_CON1, ctl(1'b0, 1'b0, MODE_SET));
      repeat (2) @(posedge aclk);
      chk(32'(unit_pin_out[0]), 32'h0, "level after disable");
    end
  endtask : t_compare

  task automatic t_pwm();
    logic [31:0] v [3] = '{32'h0004, 32'h0200, 32'h0000};
    int          h [3];
    for (int i = 0; i < 3; i++)
    begin
      wr(`CCPT_IDX_CON1, ctl(1'b1, i == 1, ccpt_mode_type'(4'hC + 4'(i))));
      wr(`CCPT_IDX_VAL1, v[i]);
      repeat (40) @(posedge aclk);
      h[i] = nhigh;
      repeat (64) @(posedge aclk);
      h[i] = nhigh - h[i];
    end
    // Duty 8 left-aligned against duty 4 right-aligned, four periods of 16
    chk(32'(h[1] - h[0]), 32'd16, "duty difference");
    chk(32'(h[2]), 32'h0, "zero duty");
    chk(32'(nclr1 > 0), 32'h1, "timer2 clears");
    wr(`CCPT_IDX_TSEL, 32'h6);
    repeat (20) @(posedge aclk);
    chk(32'(nclr3 > 0), 32'h1, "timer4 clears");
    wr(`CCPT_IDX_VAL1, 32'hFFFF);
    rchk(`CCPT_IDX_VAL1, 32'h03FF);
    wr(`CCPT_IDX_CON1, ctl(1'b1, 1'b1, MODE_PWM_3));
    wr(`CCPT_IDX_VAL1, 32'hFFFF);
    rchk(`CCPT_IDX_VAL1, 32'hFFC0);
  endtask : t_pwm

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, hold, restart} = 7'h00;
    {awaddr, araddr, wdata, src} = 72'h0;
    {miscompares, comparisons, nflag, nclr0, nclr2, nhigh, nflag2, nclr1, nclr3} = '0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    do_reset();
    t_regs();
    t_capval();
    t_capture();
    t_compare();
    t_pwm();
    stop_test();
  end

  initial
  begin
    #800000;
    miscompares++;
    stop_test();
  end
endmodule : testbench
